// ===== uemr_pkg.sv
/*
  Shared constants and types for the USB endpoint mode responder.
  Assumes an 8-bit processor IO space and an engine clock of 200 MHz.
*/
package uemr_pkg;
  localparam int unsigned EP_COUNT     = 3;
  localparam int unsigned BUF_BYTES    = 8;
  localparam logic [7:0]  ADDR_EP1_MODE = 8'h45;
  localparam logic [7:0]  ADDR_EP2_MODE = 8'h46;
  localparam logic [7:0]  ADDR_EP0BUF  = 8'h50;
  localparam logic [7:0]  ADDR_EP1BUF  = 8'h58;
  localparam logic [7:0]  ADDR_EP2BUF  = 8'h60;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam int unsigned BIT_STALL    = 7;
  localparam int unsigned BIT_RSVD     = 6;
  localparam int unsigned BIT_NAK_IE   = 5;
  localparam int unsigned BIT_ACKD     = 4;
  localparam int unsigned MODE_MSB     = 3;
  localparam logic [3:0]  RX_LEN_MAX   = 4'ha;
  localparam logic [3:0]  RX_LEN_ZERO  = 4'h2;

  typedef enum logic [3:0] {
    UEMR_M_DISABLE  = 4'b0000,
    UEMR_M_NAK_IO   = 4'b0001,
    UEMR_M_STAT_OUT = 4'b0010,
    UEMR_M_STALL_IO = 4'b0011,
    UEMR_M_STAT_IN  = 4'b0110,
    UEMR_M_ACKO_SIN = 4'b1011,
    UEMR_M_ACKI_SO  = 4'b1111,
    UEMR_M_NAK_OUT  = 4'b1000,
    UEMR_M_ACK_OUT  = 4'b1001,
    UEMR_M_NAK_IN   = 4'b1100,
    UEMR_M_ACK_IN   = 4'b1101
  } uemr_mode_t;

  typedef enum logic [1:0] {
    UEMR_T_OUT   = 2'b00,
    UEMR_T_IN    = 2'b01,
    UEMR_T_SETUP = 2'b10
  } uemr_tok_t;

  typedef enum logic [2:0] {
    UEMR_R_IGNORE = 3'b000,
    UEMR_R_ACK    = 3'b001,
    UEMR_R_NAK    = 3'b010,
    UEMR_R_STALL  = 3'b011,
    UEMR_R_DATA   = 3'b100
  } uemr_resp_t;

  typedef enum logic [1:0] {
    UEMR_S_IDLE = 2'b00,
    UEMR_S_TX   = 2'b01,
    UEMR_S_HS   = 2'b10
  } uemr_state_t;
endpackage

// ===== uemr_ep_buffer.sv
/*
  One endpoint data buffer: an engine write port, a processor write port
  and two asynchronous read ports. Contents are not reset.
  Assumes both writers run on clk_sys.
*/
module uemr_ep_buffer #(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                     clk_sys,
  input  wire logic                     eng_we,
  input  wire logic [$clog2(DEPTH)-1:0] eng_idx,
  input  wire logic [7:0]               eng_wdata,
  input  wire logic                     cpu_we,
  input  wire logic [$clog2(DEPTH)-1:0] cpu_idx,
  input  wire logic [7:0]               cpu_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [7:0]               cpu_rdata,
  output logic      [7:0]               rd_data
);
  logic [7:0] mem [DEPTH];

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("buffer depth must be a power of two");
  end

  // no reset on contents
  // engine wins a same-cycle clash so received data is never lost
  always_ff @(posedge clk_sys) begin
    if (eng_we) begin
      mem[eng_idx] <= eng_wdata;
    end
    if (cpu_we && !(eng_we && eng_idx == cpu_idx)) begin
      mem[cpu_idx] <= cpu_wdata;
    end
  end

  assign cpu_rdata = mem[cpu_idx];
  assign rd_data   = mem[rd_idx];
endmodule

// ===== usb_endpoint_mode_responder.sv
/*
  Endpoint response logic of a low-speed USB serial_interface_engine:
  decides the handshake for each token, streams counted IN data from the
  endpoint buffers, auto-advances data endpoint modes, and holds the two
  data endpoint mode registers and three endpoint buffers in IO space.
  Assumes packet decode, CRC, toggle and line coding live elsewhere and
  present one decision request per transaction on clk_sys.
//
// Function
// - stall bit stalls ACK-OUT/ACK-IN traffic
// - NAK events only when enable set
// - ACK completion sets acknowledged flag
// - firmware mode write clears acknowledged flag
// - engine update blocks same-cycle firmware write
// - three 8-byte buffers at fixed bases
// - buffers IO-only, contents undefined after reset
// - mode 0000 ignores every token
// - 0001: accept SETUP, NAK IN/OUT
// - 0010: SETUP, STALL IN, check OUT
// - 0011: SETUP, STALL IN and OUT
// - 0110: SETUP, STALL OUT, zero IN
// - 1011: SETUP, ACK OUT, zero IN
// - 1111: SETUP, counted IN, check OUT
// - 1000 NAKs OUT, 1100 NAKs IN
// - 1001 ACKs OUT, then becomes 1000
// - 1101 sends data, host ACK gives 1100
// - reserved modes ignore all tokens
// - check: ACK zero length toggle one
// - IN data sends exactly byte count
*/
module usb_endpoint_mode_responder
  import uemr_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = uemr_pkg::BUF_BYTES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic [7:0]            io_addr,
  input  wire logic [7:0]            io_wdata,
  input  wire logic                  io_wr,
  input  wire logic                  io_rd,
  output logic      [7:0]            io_rdata,
  input  wire logic [3:0]            ctl_mode,
  input  wire logic [11:0]           ep_byte_count,
  input  wire logic                  tok_valid,
  input  wire uemr_pkg::uemr_tok_t   tok_type,
  input  wire logic [1:0]            tok_ep,
  input  wire logic [3:0]            rx_len,
  input  wire logic                  rx_ok,
  input  wire logic                  rx_toggle,
  input  wire logic                  rx_wr,
  input  wire logic [1:0]            rx_ep,
  input  wire logic [2:0]            rx_idx,
  input  wire logic [7:0]            rx_byte,
  output logic                       resp_valid,
  output uemr_pkg::uemr_resp_t       resp_code,
  output logic      [3:0]            resp_len,
  output logic                       tx_valid,
  output logic      [7:0]            tx_data,
  output logic                       tx_last,
  input  wire logic                  tx_ready,
  input  wire logic                  hs_valid,
  input  wire logic                  hs_ack,
  output logic      [2:0]            ep_event,
  output logic                       busy
);
  import uemr_pkg::*;

  localparam int unsigned IW = $clog2(BUF_DEPTH);

  if (BUF_DEPTH != BUF_BYTES) begin : g_chk
    $error("endpoint buffer depth must match the 3-bit byte index");
  end

  typedef struct packed {
    uemr_state_t     st;
    logic [1:0]      ep;
    logic [3:0]      left;
    logic [2:0]      idx;
    logic [1:0][7:0] mreg;
    uemr_resp_t      resp;
    logic            resp_vld;
    logic [3:0]      rlen;
    logic [7:0]      txd;
    logic            txv;
    logic            txl;
    logic [2:0]      evt;
    logic [7:0]      rdata;
  } uemr_regs_t;

  uemr_regs_t r;
  uemr_regs_t next_r;

  logic [2:0][7:0] buf_cpu_rd;
  logic [2:0][7:0] buf_tx_rd;
  logic [2:0]      buf_sel;
  logic            cpu_buf_we;

  // buffer decode on 8-byte aligned bases
  assign buf_sel[0] = (io_addr[7:3] == ADDR_EP0BUF[7:3]);
  assign buf_sel[1] = (io_addr[7:3] == ADDR_EP1BUF[7:3]);
  assign buf_sel[2] = (io_addr[7:3] == ADDR_EP2BUF[7:3]);
  assign cpu_buf_we = io_wr;

  for (genvar g = 0; g < EP_COUNT; g++) begin : g_buf
    uemr_ep_buffer #(
      .DEPTH (BUF_DEPTH)
    ) u_buf (
      .clk_sys   (clk_sys),
      .eng_we    (rx_wr && rx_ep == 2'(g)),
      .eng_idx   (rx_idx),
      .eng_wdata (rx_byte),
      .cpu_we    (cpu_buf_we && buf_sel[g]),
      .cpu_idx   (io_addr[IW-1:0]),
      .cpu_wdata (io_wdata),
      .rd_idx    (r.idx),
      .cpu_rdata (buf_cpu_rd[g]),
      .rd_data   (buf_tx_rd[g])
    );
  end

  function automatic logic [3:0] count_of(input logic [1:0] ep, input logic [11:0] cnt);
    logic [3:0] c;
    c = cnt[3:0];
    case (ep)
      2'd1:    c = cnt[7:4];
      2'd2:    c = cnt[11:8];
      default: c = cnt[3:0];
    endcase
    return c;
  endfunction

  // handshake decision for one transaction
  function automatic uemr_resp_t decide(input logic ep0, input logic [3:0] mode,
                                        input logic stall, input uemr_tok_t tok,
                                        input logic good, input logic zero_tog1);
    uemr_resp_t d;
    d = UEMR_R_IGNORE;
    if (ep0) begin
      case (mode)
        UEMR_M_NAK_IO, UEMR_M_STAT_OUT, UEMR_M_STALL_IO, UEMR_M_STAT_IN,
        UEMR_M_ACKO_SIN, UEMR_M_ACKI_SO: begin
          if (tok == UEMR_T_SETUP) begin
            d = good ? UEMR_R_ACK : UEMR_R_IGNORE;
          end else if (tok == UEMR_T_IN) begin
            case (mode)
              UEMR_M_NAK_IO:   d = UEMR_R_NAK;
              UEMR_M_STAT_IN,
              UEMR_M_ACKO_SIN: d = UEMR_R_DATA;
              UEMR_M_ACKI_SO:  d = UEMR_R_DATA;
              default:         d = UEMR_R_STALL;
            endcase
          end else if (good) begin
            case (mode)
              UEMR_M_NAK_IO:   d = UEMR_R_NAK;
              UEMR_M_ACKO_SIN: d = UEMR_R_ACK;
              UEMR_M_STAT_OUT,
              UEMR_M_ACKI_SO:  d = zero_tog1 ? UEMR_R_ACK : UEMR_R_STALL;
              default:         d = UEMR_R_STALL;
            endcase
          end
        end
        default: d = UEMR_R_IGNORE;
      endcase
    end else begin
      case (mode)
        UEMR_M_NAK_OUT: d = (tok == UEMR_T_OUT && good) ? UEMR_R_NAK : UEMR_R_IGNORE;
        UEMR_M_NAK_IN:  d = (tok == UEMR_T_IN) ? UEMR_R_NAK : UEMR_R_IGNORE;
        UEMR_M_ACK_OUT: begin
          if (tok == UEMR_T_OUT && good) begin
            d = stall ? UEMR_R_STALL : UEMR_R_ACK;
          end
        end
        // stall or send the IN data
        UEMR_M_ACK_IN: begin
          if (tok == UEMR_T_IN) begin
            d = stall ? UEMR_R_STALL : UEMR_R_DATA;
          end
        end
        default: d = UEMR_R_IGNORE;
      endcase
    end
    return d;
  endfunction

  uemr_resp_t dec;
  logic [3:0] tok_mode;
  logic [7:0] tok_mreg;

  always_comb begin
    tok_mreg = (tok_ep == 2'd2) ? r.mreg[1] : r.mreg[0];
    // current register value steers each ep1/ep2 token, ctl_mode steers each ep0 token
    tok_mode = (tok_ep == 2'd0) ? ctl_mode : tok_mreg[MODE_MSB:0];
    dec = decide(tok_ep == 2'd0, tok_mode, tok_mreg[BIT_STALL], tok_type,
                 rx_ok && rx_len <= RX_LEN_MAX,
                 rx_len == RX_LEN_ZERO && rx_toggle);
  end

  // engine update request into the shared mode update strobe
  logic       eng_upd;
  logic       eng_slot;
  logic [3:0] eng_mode;

  always_comb begin
    next_r          = r;
    next_r.resp_vld = 1'b0;
    next_r.evt      = 3'b000;
    eng_upd         = 1'b0;
    eng_slot        = 1'b0;
    eng_mode        = UEMR_M_DISABLE;

    case (r.st)
      UEMR_S_IDLE: begin
        if (tok_valid && tok_ep != 2'd3) begin
          next_r.ep   = tok_ep;
          next_r.resp = dec;
          next_r.rlen = 4'h0;
          next_r.idx  = 3'd0;
          if (dec != UEMR_R_IGNORE) begin
            next_r.resp_vld = 1'b1;
          end
          case (dec)
            UEMR_R_ACK: begin
              next_r.evt[tok_ep] = 1'b1;
              if (tok_ep != 2'd0) begin
                // ACK issued, fall back to NAK OUT
                eng_upd  = 1'b1;
                eng_slot = tok_ep[1];
                eng_mode = UEMR_M_NAK_OUT;
              end
            end
            UEMR_R_NAK: begin
              if (tok_ep != 2'd0 && tok_mreg[BIT_NAK_IE]) begin
                next_r.evt[tok_ep] = 1'b1;
              end
            end
            UEMR_R_DATA: begin
              if (tok_mode == UEMR_M_ACKI_SO || tok_mode == UEMR_M_ACK_IN) begin
                next_r.rlen = count_of(tok_ep, ep_byte_count);
                next_r.left = count_of(tok_ep, ep_byte_count);
              end else begin
                next_r.left = 4'h0;
              end
              next_r.st = UEMR_S_TX;
            end
            default: next_r.st = UEMR_S_IDLE;
          endcase
        end
      end
      UEMR_S_TX: begin
        if (!r.txv || tx_ready) begin
          if (r.left != 4'h0) begin
            next_r.txv  = 1'b1;
            next_r.txd  = buf_tx_rd[r.ep];
            next_r.txl  = (r.left == 4'h1);
            next_r.left = r.left - 4'h1;
            next_r.idx  = r.idx + 3'd1;
          end else begin
            next_r.txv = 1'b0;
            next_r.txl = 1'b0;
            next_r.st  = UEMR_S_HS;
          end
        end
      end
      UEMR_S_HS: begin
        if (hs_valid) begin
          next_r.st = UEMR_S_IDLE;
          if (hs_ack) begin
            next_r.evt[r.ep] = 1'b1;
            if (r.ep != 2'd0) begin
              // host ACK, fall back to NAK IN
              eng_upd  = 1'b1;
              eng_slot = r.ep[1];
              eng_mode = UEMR_M_NAK_IN;
            end
          end
        end
      end
      default: next_r.st = UEMR_S_IDLE;
    endcase

    // firmware side of the mode registers
    for (int k = 0; k < 2; k++) begin
      if (io_wr && !eng_upd && io_addr == (k == 0 ? ADDR_EP1_MODE : ADDR_EP2_MODE)) begin
        next_r.mreg[k]           = io_wdata;
        next_r.mreg[k][BIT_ACKD] = 1'b0;
      end
    end
    // engine update owns the strobe this cycle
    if (eng_upd) begin
      next_r.mreg[eng_slot][MODE_MSB:0] = eng_mode;
      next_r.mreg[eng_slot][BIT_ACKD]   = 1'b1;
    end

    // registered read data, zero for unmapped addresses
    next_r.rdata = 8'h00;
    if (io_rd) begin
      if (io_addr == ADDR_EP1_MODE) begin
        next_r.rdata = r.mreg[0];
      end else if (io_addr == ADDR_EP2_MODE) begin
        next_r.rdata = r.mreg[1];
      end else begin
        for (int b = 0; b < EP_COUNT; b++) begin
          if (buf_sel[b]) begin
            next_r.rdata = buf_cpu_rd[b];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r.st       <= UEMR_S_IDLE;
      r.ep       <= 2'd0;
      r.left     <= 4'h0;
      r.idx      <= 3'd0;
      r.mreg     <= {MODE_RESET, MODE_RESET};
      r.resp     <= UEMR_R_IGNORE;
      r.resp_vld <= 1'b0;
      r.rlen     <= 4'h0;
      r.txd      <= 8'h00;
      r.txv      <= 1'b0;
      r.txl      <= 1'b0;
      r.evt      <= 3'b000;
      r.rdata    <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  assign io_rdata   = r.rdata;
  assign resp_valid = r.resp_vld;
  assign resp_code  = r.resp;
  assign resp_len   = r.rlen;
  assign tx_valid   = r.txv;
  assign tx_data    = r.txd;
  assign tx_last    = r.txl;
  assign ep_event   = r.evt;
  assign busy       = (r.st != UEMR_S_IDLE);
endmodule

// ===== uemr_asserts.sv
/*
  Port checks for the endpoint mode responder.
  Assumes one clock, clk_sys, and srst high as its reset.
*/
module uemr_asserts
  import uemr_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 srst,
  input wire logic                 io_rd,
  input wire logic [7:0]           io_rdata,
  input wire logic [3:0]           ctl_mode,
  input wire logic                 tok_valid,
  input wire uemr_pkg::uemr_tok_t  tok_type,
  input wire logic [1:0]           tok_ep,
  input wire logic                 resp_valid,
  input wire uemr_pkg::uemr_resp_t resp_code,
  input wire logic [3:0]           resp_len,
  input wire logic                 tx_valid,
  input wire logic                 tx_last,
  input wire logic                 tx_ready,
  input wire logic [2:0]           ep_event,
  input wire logic                 busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] beats;
  logic       ctl_tok;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  assign ctl_tok = tok_valid && !busy && tok_ep == 2'd0;

  // bytes taken since the last decision
  always_ff @(posedge clk_sys) begin
    if (srst || resp_valid) beats <= 4'h0;
    else if (tx_valid && tx_ready) beats <= beats + 4'h1;
  end

  a_idle_ignore: assert property (ctl_tok && ctl_mode == 4'h0 |=> !resp_valid)
    else $error("disabled endpoint answered");
  a_rsvd_ignore: assert property (ctl_tok && ctl_mode inside {4'h4, 4'h5, 4'h7, 4'ha, 4'he}
    |=> !resp_valid)
    else $error("unsupported mode answered");
  a_ctl_nak: assert property (ctl_tok && ctl_mode == 4'h1 && tok_type == UEMR_T_IN
    |=> resp_valid && resp_code == UEMR_R_NAK)
    else $error("IN not refused with NAK");
  a_ctl_stall: assert property (ctl_tok && ctl_mode == 4'h3 && tok_type == UEMR_T_IN
    |=> resp_valid && resp_code == UEMR_R_STALL)
    else $error("IN not stalled");
  a_zero_in: assert property (ctl_tok && ctl_mode inside {4'h6, 4'hb} && tok_type == UEMR_T_IN
    |=> resp_code == UEMR_R_DATA && resp_len == 4'h0)
    else $error("status IN not zero length");
  a_ack_event: assert property (resp_valid && resp_code == UEMR_R_ACK |-> ep_event != 3'h0)
    else $error("ACK without endpoint event");
  a_tx_count: assert property (tx_valid && tx_ready && tx_last |-> beats + 4'h1 == resp_len)
    else $error("byte count differs from reply length");
  a_rdata_quiet: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
    else $error("read data without a read");
endmodule

bind usb_endpoint_mode_responder uemr_asserts i_chk (.clk_sys, .srst, .io_rd, .io_rdata, .ctl_mode,
  .tok_valid, .tok_type, .tok_ep, .resp_valid, .resp_code, .resp_len, .tx_valid, .tx_last,
  .tx_ready, .ep_event, .busy);

// ===== uemr_host_model.sv
/*
  Host on the far side: takes IN data bytes, then sends the handshake.
  Assumes the bench sets slow and ack_en before each IN transfer.
*/
module uemr_host_model (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic       ack_en,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  input  wire logic       busy,
  output logic            tx_ready,
  output logic            hs_valid,
  output logic            hs_ack
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] got [$];
  int         gap;
  int         last_at;

  always @(posedge clk_sys) begin
    // slow host refuses every other beat
    tx_ready <= !srst && (!slow || !tx_ready);
    if (tx_valid && tx_ready) got.push_back(tx_data);
    // bytes taken up to and including the one marked last
    if (tx_valid && tx_ready && tx_last) last_at <= got.size();
    gap <= (busy && !tx_valid && !hs_valid) ? gap + 1 : 0;
    hs_valid <= !srst && gap == 2;
    // ack line toggles every cycle outside the handshake and is held high in reset
    hs_ack <= (gap == 2) ? ack_en : (srst || !hs_ack);
  end
endmodule

// ===== usb_endpoint_mode_responder_tb_top.sv
/*
  Self-checking bench for the endpoint mode responder and a host model.
  Assumes a 200 MHz clock; inputs change on the falling edge.
*/
module usb_endpoint_mode_responder_tb_top
  import uemr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys = 1'b0, srst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, tok_valid = 1'b0;
  logic        rx_ok = 1'b1, rx_toggle = 1'b1, rx_wr = 1'b0, slow = 1'b0, ack_en = 1'b1;
  logic [7:0]  io_addr = 8'h00, io_wdata = 8'h00, rx_byte = 8'h00, io_rdata, tx_data;
  logic [3:0]  ctl_mode = 4'h0, rx_len = 4'h2, resp_len;
  logic [11:0] ep_byte_count = 12'h000;
  logic [1:0]  tok_ep = 2'h0, rx_ep = 2'h0;
  logic [2:0]  rx_idx = 3'h0, ep_event, ev, rc;
  logic        resp_valid, tx_valid, tx_last, tx_ready, hs_valid, hs_ack, busy;
  uemr_tok_t   tok_type = UEMR_T_OUT;
  uemr_resp_t  resp_code;
  int          errors = 0, checks_done = 0;

  always #2.5 clk_sys = ~clk_sys;

  usb_endpoint_mode_responder i_dut (.clk_sys, .srst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .ctl_mode, .ep_byte_count, .tok_valid, .tok_type, .tok_ep, .rx_len, .rx_ok, .rx_toggle, .rx_wr,
    .rx_ep, .rx_idx, .rx_byte, .resp_valid, .resp_code, .resp_len, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .hs_valid, .hs_ack, .ep_event, .busy);
  uemr_host_model i_host (.clk_sys, .srst, .slow, .ack_en, .tx_valid, .tx_data, .tx_last, .busy, .tx_ready,
    .hs_valid, .hs_ack);

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
    // idle cycle keeps strobes of back-to-back calls apart
    @(negedge clk_sys);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
    chk(what, io_rdata, exp);
    @(negedge clk_sys);
  endtask

  // one token; a data reply is followed to its end
  task automatic tok(input uemr_tok_t t, input logic [1:0] ep);
    tok_type = t;
    tok_ep = ep;
    tok_valid = 1'b1;
    @(negedge clk_sys);
    tok_valid = 1'b0;
    rc = resp_valid ? resp_code : 3'h0;
    ev = ep_event;
    for (int i = 0; busy && i < 300; i++) @(negedge clk_sys);
    if (busy) begin
      errors++;
      test_done();
    end
    if (rc == UEMR_R_DATA) ev = ep_event;
    @(negedge clk_sys);
  endtask

  task automatic sc_regs();
    rchk("mode1 reset", ADDR_EP1_MODE, 8'h00);
    rchk("mode2 reset", ADDR_EP2_MODE, 8'h00);
    rchk("unmapped", 8'h70, 8'h00);
    wr(ADDR_EP1_MODE, 8'h7c);
    rchk("mode stored", ADDR_EP1_MODE, 8'h6c);
    wr(ADDR_EP1_MODE, 8'h00);
  endtask

  task automatic sc_buf();
    for (int i = 0; i < 24; i++) wr(ADDR_EP0BUF + 8'(i), 8'ha0 + 8'(i));
    rx_idx = 3'h7;
    rx_byte = 8'h5c;
    rx_wr = 1'b1;
    @(negedge clk_sys);
    rx_wr = 1'b0;
    for (int i = 0; i < 24; i++) rchk("buffer", ADDR_EP0BUF + 8'(i), i == 7 ? 8'h5c : 8'ha0 + 8'(i));
  endtask

  task automatic sc_ctl();
    logic [3:0]  m [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'hb, 4'hf, 4'h4, 4'h5, 4'h7, 4'ha, 4'he};
    logic [11:0] e [12] = '{12'h000, 12'h122, 12'h131, 12'h133, 12'h143, 12'h141, 12'h141,
                           12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
    uemr_tok_t   tt [3] = '{UEMR_T_SETUP, UEMR_T_IN, UEMR_T_OUT};
    for (int i = 0; i < 12; i++) begin
      ctl_mode = m[i];
      for (int t = 0; t < 3; t++) begin
        tok(tt[t], 2'h0);
        chk("ctl", rc, e[i][4*(2-t)+:4]);
      end
    end
    ctl_mode = 4'h2;
    rx_toggle = 1'b0;
    tok(UEMR_T_OUT, 2'h0);
    chk("status toggle0", rc, UEMR_R_STALL);
    rx_toggle = 1'b1;
    rx_len = 4'h3;
    tok(UEMR_T_OUT, 2'h0);
    chk("status length", rc, UEMR_R_STALL);
    rx_len = 4'h2;
    ctl_mode = 4'hf;
    ep_byte_count = 12'h002;
    i_host.got.delete();
    tok(UEMR_T_IN, 2'h0);
    chk("ctl data len", resp_len, 12'h002);
    chk("ctl count", 12'(i_host.got.size()), 12'h002);
    chk("ctl byte0", i_host.got[0], 12'h0a0);
    chk("ctl byte1", i_host.got[1], 12'h0a1);
    chk("ctl last", 12'(i_host.last_at), 12'h002);
  endtask

  task automatic sc_out();
    wr(ADDR_EP1_MODE, 8'h29);
    tok(UEMR_T_IN, 2'h1);
    chk("ack-out IN", rc, 12'h000);
    tok(UEMR_T_OUT, 2'h1);
    chk("ack-out reply", {rc, ev}, {UEMR_R_ACK, 3'b010});
    rchk("ack-out mode", ADDR_EP1_MODE, 8'h38);
    tok(UEMR_T_OUT, 2'h1);
    chk("nak event", {rc, ev}, {UEMR_R_NAK, 3'b010});
    wr(ADDR_EP1_MODE, 8'h08);
    rchk("write clears flag", ADDR_EP1_MODE, 8'h08);
    tok(UEMR_T_OUT, 2'h1);
    chk("nak quiet", {rc, ev}, {UEMR_R_NAK, 3'b000});
    wr(ADDR_EP1_MODE, 8'h89);
    tok(UEMR_T_OUT, 2'h1);
    chk("stalled OUT", rc, UEMR_R_STALL);
    wr(ADDR_EP1_MODE, 8'h00);
  endtask

  task automatic sc_in();
    ep_byte_count = 12'h300;
    wr(ADDR_EP2_MODE, 8'h0d);
    slow = 1'b1;
    i_host.got.delete();
    tok(UEMR_T_IN, 2'h2);
    chk("in reply", {rc, ev, 2'h0, resp_len}, {UEMR_R_DATA, 3'b100, 6'h03});
    chk("in count", 12'(i_host.got.size()), 12'h003);
    chk("in last", 12'(i_host.last_at), 12'h003);
    for (int k = 0; k < 3; k++) chk("in byte", i_host.got[k], 8'hb0 + 8'(k));
    rchk("in mode", ADDR_EP2_MODE, 8'h1c);
    ep_byte_count = 12'h800;
    wr(ADDR_EP2_MODE, 8'h0d);
    slow = 1'b0;
    ack_en = 1'b0;
    i_host.got.delete();
    tok(UEMR_T_IN, 2'h2);
    chk("no ack", {ev, 1'b0, 8'(i_host.got.size())}, 12'h008);
    chk("no ack last", 12'(i_host.last_at), 12'h008);
    rchk("no ack mode", ADDR_EP2_MODE, 8'h0d);
    ack_en = 1'b1;
    wr(ADDR_EP2_MODE, 8'h8d);
    tok(UEMR_T_IN, 2'h2);
    chk("stalled IN", rc, UEMR_R_STALL);
    tok(UEMR_T_OUT, 2'h2);
    chk("ack-in OUT", rc, 12'h000);
    wr(ADDR_EP2_MODE, 8'h0c);
    tok(UEMR_T_IN, 2'h2);
    chk("nak IN", rc, UEMR_R_NAK);
  endtask

  task automatic sc_collide();
    wr(ADDR_EP1_MODE, 8'h09);
    // firmware write to ep2 meets the engine update of ep1
    io_addr = ADDR_EP2_MODE;
    io_wdata = 8'h08;
    io_wr = 1'b1;
    tok_type = UEMR_T_OUT;
    tok_ep = 2'h1;
    tok_valid = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
    tok_valid = 1'b0;
    chk("collide reply", resp_code, UEMR_R_ACK);
    @(negedge clk_sys);
    rchk("blocked write", ADDR_EP2_MODE, 8'h0c);
    rchk("engine write", ADDR_EP1_MODE, 8'h18);
    wr(ADDR_EP2_MODE, 8'h08);
    rchk("rewrite", ADDR_EP2_MODE, 8'h08);
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    sc_regs();
    sc_buf();
    sc_ctl();
    sc_out();
    sc_in();
    sc_collide();
    test_done();
  end
endmodule
